// [common/cascade_timer_defines.svh]
// Register indices, field positions, reset values and prescaler constants
`ifndef CASCADE_TIMER_DEFINES_SVH
`define CASCADE_TIMER_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_LOW_MODE 8'h23
`define IDX_PAIR_CTRL 8'h24
`define IDX_CASCADE_MODE 8'h25
`define IDX_COMPARE_LOW 8'h26
`define IDX_COMPARE_HIGH 8'h27
`define IDX_PWM_LOW 8'h28
`define IDX_PWM_HIGH 8'h29
`define IDX_COUNT_STATUS 8'h2a

// Reset values
`define RST_PWM_LOW 8'hff
`define RST_PWM_HIGH 8'hff
`define RST_PWM_VALUE 12'hfff
`define RST_CTRL 8'h00
`define RST_MODE 8'h00
`define RST_COMPARE 16'h0000

// Operating mode field encodings
`define OPM_PWM12 2'b10
`define OPM_PPG16 2'b11

// Field positions inside the combined PWM value
`define PWM_DUTY_HI_MSB 11
`define PWM_DUTY_HI_LSB 8
`define PWM_DUTY_LO_MSB 7
`define PWM_DUTY_LO_LSB 4
`define PWM_EXTRA_MSB 3

// Frame and overflow figures
`define LOW_BYTE_TOP 8'hff
`define FRAME_LAST 4'hf
`define PRESCALE_W 11

`endif

// [common/cascade_timer_pkg.sv]
// Types shared by the cascaded counter and its source clock generator
package cascade_timer_pkg;

  // Cascaded mode register layout, msb first
  typedef struct packed {
    logic dbe;
    logic [2:0] clk_sel;
    logic lvl_sel;
    logic ext_sel;
    logic [1:0] op_mode;
  } mode_reg_t;

  // Pair control register layout, msb first
  typedef struct packed {
    logic [4:0] spare;
    logic cascade;
    logic high_run;
    logic low_run;
  } ctrl_reg_t;

  // What the counter is doing this cycle
  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_COUNT,
    RUN_PWM
  } run_mode_t;

endpackage

// [hw/source_tick_gen.sv]
// Source clock tick generator: prescaler taps and external pin edge detect
`timescale 1ns/100ps
module source_tick_gen
  import cascade_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] clk_sel_i,
  input wire logic ext_sel_i,
  input wire logic ext_pin_i,
  output logic tick_o
);
`include "cascade_timer_defines.svh"

  logic [`PRESCALE_W-1:0] div_q;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic fall;
  logic pre_tick;

  // Mask of prescaler bits that must be all ones for one tick
  function automatic logic [`PRESCALE_W-1:0] tap_mask(logic [2:0] sel);
    case (sel)
      3'h0: tap_mask = 11'h7ff;
      3'h1: tap_mask = 11'h3ff;
      3'h2: tap_mask = 11'h0ff;
      3'h3: tap_mask = 11'h03f;
      3'h4: tap_mask = 11'h00f;
      3'h5: tap_mask = 11'h003;
      3'h6: tap_mask = 11'h001;
      default: tap_mask = 11'h000;
    endcase
  endfunction

  // Free running prescaler
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= '0;
    else
      div_q <= div_q + 11'h001;
  end

  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
    end
    else
    begin
      sync1_q <= ext_pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // One pulse per falling edge, one per prescaler period
  assign fall = sync3_q & ~sync2_q;
  assign pre_tick = (div_q & tap_mask(clk_sel_i)) == tap_mask(clk_sel_i);

  // Source selection, registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= ext_sel_i ? fall : pre_tick;
  end

endmodule

// [hw/cascaded_event_counter_pwm12.sv]
// Cascaded 16-bit event counter and 12-bit PWM with a Wishbone slave
`timescale 1ns/100ps
module cascaded_event_counter_pwm12
  import cascade_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic external_count_pin_i,
  output logic pwm_output_pin_o,
  output logic high_timer_irq_o,
  output logic low_timer_irq_o
);
`include "cascade_timer_defines.svh"

  ctrl_reg_t ctrl_q;
  mode_reg_t mode_q;
  logic [7:0] low_mode_q;
  logic [7:0] compare_low_q;
  logic [15:0] cmp_buf_q;
  logic [15:0] cmp_act_q;
  logic [7:0] pwm_low_q;
  logic [7:0] pwm_high_q;
  logic [11:0] pwm_act_q;
  logic [15:0] cnt_q;
  logic [3:0] frame_q;
  logic tick;
  logic active;
  run_mode_t run_mode;
  logic wr;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rdata;
  logic [15:0] cnt_nxt;
  logic cmp_hit;
  logic overflow;
  logic frame_end;
  logic [7:0] duty;
  logic [8:0] toggle_at;

  // Next counter value, shared by the compare check and the counter
  function automatic logic [15:0] next_count(logic [15:0] cnt);
    next_count = cnt + 16'h0001;
  endfunction

  // Whether the frame slot gets the one-count extra pulse
  function automatic logic extra_pulse(logic [3:0] frame, logic [3:0] en);
    logic hit;
    hit = 1'b0;
    if (en[0] && frame == 4'h8)
      hit = 1'b1;
    if (en[1] && frame[2:0] == 3'h4)
      hit = 1'b1;
    if (en[2] && frame[1:0] == 2'h2)
      hit = 1'b1;
    if (en[3] && frame[0])
      hit = 1'b1;
    extra_pulse = hit;
  endfunction

  // Mode decode; only the high timer fields steer the pair
  function automatic run_mode_t run_decode(ctrl_reg_t c, mode_reg_t m);
    run_mode_t r;
    r = RUN_IDLE;
    if (c.cascade && c.high_run)
    begin
      case (m.op_mode)
        `OPM_PWM12: r = RUN_PWM;
        `OPM_PPG16: r = RUN_IDLE;
        default: r = RUN_COUNT;
      endcase
    end
    run_decode = r;
  endfunction

  // Source clock ticks from prescaler or external pin
  source_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_sel_i(mode_q.clk_sel),
    .ext_sel_i(mode_q.ext_sel),
    .ext_pin_i(external_count_pin_i),
    .tick_o(tick)
  );

  // Bus decode; a write lands on the edge where ack is seen high
  assign idx = adr_i[9:2];
  assign mapped = adr_i[31:10] == 22'h0 && adr_i[1:0] == 2'h0;
  assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0] & mapped;

  // Derived run state and event conditions
  assign run_mode = run_decode(ctrl_q, mode_q);
  assign active = run_mode != RUN_IDLE;
  assign cnt_nxt = next_count(cnt_q);
  assign cmp_hit = run_mode == RUN_COUNT && tick && cnt_nxt == cmp_act_q;
  assign overflow = run_mode == RUN_PWM && tick &&
                    cnt_q[7:0] == `LOW_BYTE_TOP;
  assign frame_end = overflow && frame_q == `FRAME_LAST;
  assign duty = {pwm_act_q[`PWM_DUTY_HI_MSB:`PWM_DUTY_HI_LSB],
                 pwm_act_q[`PWM_DUTY_LO_MSB:`PWM_DUTY_LO_LSB]};
  assign toggle_at = {1'b0, duty} +
    {8'h00, extra_pulse(frame_q, pwm_act_q[`PWM_EXTRA_MSB:0])};

  // Read multiplexer
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (mapped)
    begin
      case (idx)
        `IDX_LOW_MODE: rdata = {24'h0, low_mode_q};
        `IDX_PAIR_CTRL: rdata = {24'h0, ctrl_q};
        `IDX_CASCADE_MODE: rdata = {24'h0, mode_q};
        `IDX_COMPARE_LOW: rdata = {24'h0, compare_low_q};
        `IDX_COMPARE_HIGH: rdata = {24'h0, cmp_buf_q[15:8]};
        `IDX_PWM_LOW: rdata = {24'h0, pwm_low_q};
        `IDX_PWM_HIGH: rdata = {24'h0, pwm_high_q};
        `IDX_COUNT_STATUS: rdata = {11'h0, active, frame_q, cnt_q};
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // Wishbone answer: one wait state, ack for one cycle, data registered
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i && stb_i && !ack_o)
        dat_o <= rdata;
    end
  end

  // Control registers; the mode registers lock while either run bit is set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `RST_CTRL;
      mode_q <= `RST_MODE;
      low_mode_q <= `RST_MODE;
    end
    else if (wr)
    begin
      if (idx == `IDX_PAIR_CTRL)
        ctrl_q <= {5'h00, dat_i[2:0]};
      if (idx == `IDX_CASCADE_MODE && !ctrl_q.low_run && !ctrl_q.high_run)
        mode_q <= dat_i[7:0];
      if (idx == `IDX_LOW_MODE && !ctrl_q.low_run && !ctrl_q.high_run)
        low_mode_q <= dat_i[7:0];
    end
  end

  // Compare holding, double buffer and active value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_low_q <= 8'h00;
      cmp_buf_q <= `RST_COMPARE;
      cmp_act_q <= `RST_COMPARE;
    end
    else
    begin
      if (wr && idx == `IDX_COMPARE_LOW)
        compare_low_q <= dat_i[7:0];
      if (wr && idx == `IDX_COMPARE_HIGH)
      begin
        cmp_buf_q <= {dat_i[7:0], compare_low_q};
        if (!active || !mode_q.dbe)
          cmp_act_q <= {dat_i[7:0], compare_low_q};
      end
      else if (cmp_hit && mode_q.dbe)
        cmp_act_q <= cmp_buf_q;
    end
  end

  // PWM holding registers, buffer and active value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_low_q <= `RST_PWM_LOW;
      pwm_high_q <= `RST_PWM_HIGH;
      pwm_act_q <= `RST_PWM_VALUE;
    end
    else
    begin
      if (wr && idx == `IDX_PWM_LOW)
        pwm_low_q <= dat_i[7:0];
      if (wr && idx == `IDX_PWM_HIGH)
      begin
        pwm_high_q <= dat_i[7:0];
        if (!active || !mode_q.dbe)
          pwm_act_q <= {dat_i[3:0], pwm_low_q};
      end
      else if (frame_end && mode_q.dbe)
        pwm_act_q <= {pwm_high_q[3:0], pwm_low_q};
    end
  end

  // Up counter and frame counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 16'h0000;
      frame_q <= 4'h0;
    end
    else
    begin
      case (run_mode)
        RUN_COUNT:
        begin
          frame_q <= 4'h0;
          if (cmp_hit)
            cnt_q <= 16'h0000;
          else if (tick)
            cnt_q <= cnt_nxt;
        end
        RUN_PWM:
        begin
          if (overflow)
          begin
            cnt_q <= 16'h0000;
            frame_q <= frame_q + 4'h1;
          end
          else if (tick)
            cnt_q <= {8'h00, cnt_nxt[7:0]};
        end
        default:
        begin
          cnt_q <= 16'h0000;
          frame_q <= 4'h0;
        end
      endcase
    end
  end

  // PWM pin level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwm_output_pin_o <= 1'b0;
    else if (run_mode != RUN_PWM)
      pwm_output_pin_o <= mode_q.lvl_sel;
    else if (overflow)
      pwm_output_pin_o <= mode_q.lvl_sel ^ (duty == 8'h00 && !extra_pulse(
        frame_q + 4'h1, pwm_act_q[`PWM_EXTRA_MSB:0]));
    else if (tick && {1'b0, cnt_nxt[7:0]} == toggle_at)
      pwm_output_pin_o <= ~mode_q.lvl_sel;
  end

  // Interrupt request pulses, one cycle each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      high_timer_irq_o <= 1'b0;
      low_timer_irq_o <= 1'b0;
    end
    else
    begin
      high_timer_irq_o <= cmp_hit | frame_end;
      low_timer_irq_o <= overflow;
    end
  end

endmodule

// [tb/pulse_source.sv]
// Behavioural external pulse source driving the count pin
`timescale 1ns/100ps
module pulse_source
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [9:0] n_i,
  input wire logic [2:0] w_i,
  output logic pin_o,
  output logic busy_o
);
  // Pin idles high as if pulled up
  initial
  begin
    pin_o = 1'b1;
    busy_o = 1'b0;
  end
  // Burst of n_i falling edges, each level held w_i cycles
  always
  begin
    @(posedge clk_i);
    if (go_i)
    begin
      busy_o <= 1'b1;
      repeat (n_i)
      begin
        repeat (w_i) @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (w_i) @(posedge clk_i);
        pin_o <= 1'b1;
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// [tb/cascade_chk.sv]
// Port-level assertions for the cascaded counter and PWM block
`timescale 1ns/100ps
module cascade_chk
  import cascade_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic external_count_pin_i,
  input wire logic pwm_output_pin_o,
  input wire logic high_timer_irq_o,
  input wire logic low_timer_irq_o
);
  ctrl_reg_t ctl_q;
  mode_reg_t mod_q;
  logic [1:0] stop_q;
  logic [3:0] frm_q;
  logic [3:0] since_q;
  logic pin_q;
  logic wr;
  logic run;
  logic pwm;
  // Accepted writes, running state and mode
  assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  assign run = ctl_q.cascade & ctl_q.high_run & mod_q.op_mode != 2'h3;
  assign pwm = mod_q.op_mode == 2'h2;
  // Register shadows and cycle counters
  always_ff @(posedge clk_i)
  begin
    pin_q <= external_count_pin_i;
    if (rst_i)
    begin
      ctl_q <= 8'h00;
      mod_q <= 8'h00;
      stop_q <= 2'h0;
      frm_q <= 4'h0;
      since_q <= 4'hf;
    end
    else
    begin
      if (wr && adr_i == 32'h90)
        ctl_q <= dat_i[7:0];
      if (wr && adr_i == 32'h94 && !ctl_q.low_run && !ctl_q.high_run)
        mod_q <= dat_i[7:0];
      stop_q <= (run | wr) ? 2'h0 : stop_q + {1'h0, stop_q != 2'h3};
      frm_q <= run ? frm_q + {3'h0, low_timer_irq_o} : 4'h0;
      since_q <= (pin_q & !external_count_pin_i) ? 4'h0 :
        since_q + {3'h0, since_q != 4'hf};
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  stop_level_a:
    assert property (stop_q == 2'h3 |-> pwm_output_pin_o == mod_q.lvl_sel)
    else $error("pin not at idle level while stopped");
  stop_quiet_a:
    assert property (stop_q == 2'h3 |-> !high_timer_irq_o && !low_timer_irq_o)
    else $error("interrupt while stopped");
  ovf_run_a:
    assert property (low_timer_irq_o |-> pwm && ($past(run) || $past(run, 2)))
    else $error("overflow pulse outside pwm run");
  high_low_a:
    assert property (pwm && high_timer_irq_o |-> low_timer_irq_o)
    else $error("frame pulse without overflow");
  frame_end_a:
    assert property (pwm && low_timer_irq_o |->
      high_timer_irq_o == (frm_q == 4'hf))
    else $error("frame pulse not on sixteenth overflow");
  edge_count_a:
    assert property (high_timer_irq_o && !pwm && mod_q.ext_sel |->
      since_q <= 4'h8)
    else $error("match pulse without recent pin fall");
  match_pulse_a:
    assert property (high_timer_irq_o |=> !high_timer_irq_o)
    else $error("match pulse longer than one cycle");
  count_no_ovf_a:
    assert property (run && !pwm |-> !low_timer_irq_o)
    else $error("overflow pulse in event mode");
endmodule
bind cascaded_event_counter_pwm12 cascade_chk cascade_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o),
  .external_count_pin_i(external_count_pin_i),
  .pwm_output_pin_o(pwm_output_pin_o),
  .high_timer_irq_o(high_timer_irq_o), .low_timer_irq_o(low_timer_irq_o));

// [tb/tb_cascaded_event_counter_pwm12.sv]
// Self-checking bench for the cascaded counter and PWM block
`timescale 1ns/100ps
module tb_cascaded_event_counter_pwm12 import cascade_timer_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic go = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] seed = 32'h6c15;
  logic [31:0] dat_o;
  logic ack_o, pin, pwm_o, hirq, lirq, busy;
  logic [9:0] n = 10'h000;
  logic [2:0] w = 3'h2;
  logic [7:0] d;
  logic [3:0] e;
  logic [63:0] ex;
  logic [63:0] exq[$];
  int errors = 0, num_checks = 0, nh = 0, c, hi, lc;
  always #5 clk_i = ~clk_i;
  cascaded_event_counter_pwm12 cascaded_event_counter_pwm12_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_pin_i(pin), .pwm_output_pin_o(pwm_o),
    .high_timer_irq_o(hirq), .low_timer_irq_o(lirq));
  pulse_source pulse_source_i (.clk_i(clk_i), .go_i(go), .n_i(n),
    .w_i(w), .pin_o(pin), .busy_o(busy));
  task check(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // One classic cycle; reads note their expected value and mask
  task wb(input logic wr_en, input logic [31:0] a, input logic [31:0] v,
    input logic [31:0] x, input logic [31:0] m);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    adr <= a;
    dat <= v;
    if (!wr_en)
      exq.push_back({m, x & m});
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Compares read data as it comes and counts match pulses
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && cyc && !we && exq.size() > 0)
    begin
      ex = exq.pop_front();
      check(dat_o & ex[63:32], ex[31:0]);
    end
    nh += (hirq === 1'b1);
  end
  // Cuts a hang short
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    give_verdict;
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 32'ha0, 0, 32'hff, 32'hff);
    wb(0, 32'ha4, 0, 32'hff, 32'hff);
    wb(1, 32'h400, 32'h5a, 0, 0);
    wb(0, 32'h400, 0, 0, 32'hffffffff);
    seed = xs(seed);
    wb(1, 32'ha0, seed, 0, 0);
    wb(1, 32'ha4, seed >> 8, 0, 0);
    wb(0, 32'ha0, 0, seed, 32'hff);
    wb(0, 32'ha4, 0, seed >> 8, 32'hff);
    // Event mode, compare 0x0102 written low then high
    wb(1, 32'h94, 32'h04, 0, 0);
    wb(1, 32'h98, 32'h02, 0, 0);
    wb(1, 32'h9c, 32'h01, 0, 0);
    wb(1, 32'h90, 32'h06, 0, 0);
    wb(1, 32'h94, 32'h0c, 0, 0);
    w <= 3'h2 + {1'b0, seed[17:16]};
    n <= 10'h104;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do
      @(posedge clk_i);
    while (busy);
    repeat (10) @(posedge clk_i);
    check(nh, 1);
    wb(0, 32'ha8, 0, 32'h00100002, 32'h0010ffff);
    wb(1, 32'h90, 32'h04, 0, 0);
    wb(0, 32'ha8, 0, 0, 32'h1fffff);
    check({31'h0, pwm_o}, 0);
    // PWM with random duty and extra pulses, both idle levels
    for (int i = 0; i < 2; i++)
    begin
      seed = xs(seed);
      d = 8'h01 + seed[7:0] % 8'hfe;
      e = i ? seed[11:8] : 4'h0;
      // Second pass buffers the value: dbe set, high idle level
      wb(1, 32'h94, {24'h0, i[0], 3'h7, i[0], 3'h2}, 0, 0);
      wb(1, 32'ha0, {24'h0, d[3:0], e}, 0, 0);
      wb(1, 32'ha4, {28'h0, d[7:4]}, 0, 0);
      wb(1, 32'h90, 32'h06, 0, 0);
      do
        @(posedge clk_i);
      while (hirq !== 1'b1);
      for (int k = 0; k <= i; k++)
      begin
        c = 0;
        hi = 0;
        lc = 0;
        fork
          if (i && k == 0)
          begin
            // Mid-frame update waits in the buffer for the frame end
            wb(1, 32'ha0, {24'h0, ~d[3:0], ~e}, 0, 0);
            wb(1, 32'ha4, {28'h0, ~d[7:4]}, 0, 0);
            wb(0, 32'ha0, 0, {24'h0, ~d[3:0], ~e}, 32'hff);
          end
          do
          begin
            @(posedge clk_i);
            c++;
            hi += (pwm_o !== i[0]);
            lc += (lirq === 1'b1);
          end
          while (hirq !== 1'b1);
        join
        check(c, 4096);
        check(lc, 16);
        check(hi, 16 * (256 - d) - e);
        d = ~d;
        e = ~e;
      end
      wb(1, 32'h90, 32'h04, 0, 0);
      wb(0, 32'ha8, 0, 0, 32'h1fffff);
    end
    give_verdict;
  end
endmodule
